// [inc/csd_pkg.sv]
`default_nettype none
package csd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// data-space geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int N_REGS = 26;
	localparam int IDX_W = 5;
	localparam logic [15:0] SFR_FIRST = 16'h0000;
	localparam logic [15:0] SFR_LAST = 16'h07FF;
	localparam int REGION_LSB = 5;
	localparam int REGION_MSB = 10;
	// one bit per aligned 32-byte region of the sfr space; only the core bank lives here
	localparam logic [63:0] REGION_IMPL = 64'h0000_0000_0000_0007;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [15:0] OFS_WORKING_REG_0 = 16'h0000;
	localparam logic [15:0] OFS_WORKING_REG_1 = 16'h0002;
	localparam logic [15:0] OFS_WORKING_REG_2 = 16'h0004;
	localparam logic [15:0] OFS_WORKING_REG_3 = 16'h0006;
	localparam logic [15:0] OFS_WORKING_REG_4 = 16'h8000;
	localparam logic [15:0] OFS_WORKING_REG_5 = 16'h000A;
	localparam logic [15:0] OFS_WORKING_REG_6 = 16'h000C;
	localparam logic [15:0] OFS_WORKING_REG_7 = 16'h000E;
	localparam logic [15:0] OFS_WORKING_REG_8 = 16'h0010;
	localparam logic [15:0] OFS_WORKING_REG_9 = 16'h0012;
	localparam logic [15:0] OFS_WORKING_REG_10 = 16'h0014;
	localparam logic [15:0] OFS_WORKING_REG_11 = 16'h0016;
	localparam logic [15:0] OFS_WORKING_REG_12 = 16'h0018;
	localparam logic [15:0] OFS_WORKING_REG_13 = 16'h001A;
	localparam logic [15:0] OFS_WORKING_REG_14 = 16'h001C;
	localparam logic [15:0] OFS_STACK_POINTER_WORKING_REG = 16'h001E;
	localparam logic [15:0] OFS_STACK_LIMIT = 16'h0020;
	localparam logic [15:0] OFS_PROGRAM_COUNTER_LOW = 16'h002E;
	localparam logic [15:0] OFS_PROGRAM_COUNTER_HIGH = 16'h0030;
	localparam logic [15:0] OFS_EXT_SPACE_READ_PAGE = 16'h0032;
	localparam logic [15:0] OFS_EXT_SPACE_WRITE_PAGE = 16'h0034;
	localparam logic [15:0] OFS_REPEAT_LOOP_COUNT = 16'h0036;
	localparam logic [15:0] OFS_CPU_STATUS_FLAGS = 16'h0042;
	localparam logic [15:0] OFS_CORE_CONTROL = 16'h0044;
	localparam logic [15:0] OFS_IRQ_DISABLE_COUNT = 16'h0052;
	localparam logic [15:0] OFS_TABLE_PAGE = 16'h0054;

	////////////////////////////////////////////////////////////////////////////////
	// implemented-bit masks and reset values
	localparam logic [15:0] MASK_FULL = 16'hFFFF;
	localparam logic [15:0] MASK_PC_HIGH = 16'h00FF;
	localparam logic [15:0] MASK_READ_PAGE = 16'h03FF;
	localparam logic [15:0] MASK_WRITE_PAGE = 16'h01FF;
	localparam logic [15:0] MASK_STATUS = 16'h01FF;
	localparam logic [15:0] MASK_CORE_CONTROL = 16'h000C;
	localparam logic [15:0] MASK_IRQ_DISABLE = 16'h3FFF;
	localparam logic [15:0] MASK_TABLE_PAGE = 16'h00FF;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_STACK_POINTER = 16'h0800;
	localparam logic [15:0] RST_PAGE = 16'h0001;
	localparam logic [15:0] RST_CORE_CONTROL = 16'h0004;
	// registers whose reset value is undefined are cleared, which is one legal value
	localparam logic [15:0] RST_UNDEFINED = 16'h0000;
	localparam int CORE_CONTROL_RESERVED_BIT = 2;

	////////////////////////////////////////////////////////////////////////////////
	// per-register tables, index order fixed
	localparam logic [15:0] REG_OFFSET [N_REGS] = '{
		OFS_WORKING_REG_0, OFS_WORKING_REG_1, OFS_WORKING_REG_2, OFS_WORKING_REG_3,
		OFS_WORKING_REG_4, OFS_WORKING_REG_5, OFS_WORKING_REG_6, OFS_WORKING_REG_7,
		OFS_WORKING_REG_8, OFS_WORKING_REG_9, OFS_WORKING_REG_10, OFS_WORKING_REG_11,
		OFS_WORKING_REG_12, OFS_WORKING_REG_13, OFS_WORKING_REG_14,
		OFS_STACK_POINTER_WORKING_REG, OFS_STACK_LIMIT, OFS_PROGRAM_COUNTER_LOW,
		OFS_PROGRAM_COUNTER_HIGH, OFS_EXT_SPACE_READ_PAGE, OFS_EXT_SPACE_WRITE_PAGE,
		OFS_REPEAT_LOOP_COUNT, OFS_CPU_STATUS_FLAGS, OFS_CORE_CONTROL,
		OFS_IRQ_DISABLE_COUNT, OFS_TABLE_PAGE};
	localparam logic [15:0] REG_MASK [N_REGS] = '{
		MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
		MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
		MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_PC_HIGH, MASK_READ_PAGE,
		MASK_WRITE_PAGE, MASK_FULL, MASK_STATUS, MASK_CORE_CONTROL, MASK_IRQ_DISABLE,
		MASK_TABLE_PAGE};
	localparam logic [15:0] REG_RESET [N_REGS] = '{
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
		RST_STACK_POINTER, RST_UNDEFINED, RST_ZERO, RST_ZERO, RST_PAGE, RST_PAGE,
		RST_UNDEFINED, RST_ZERO, RST_CORE_CONTROL, RST_UNDEFINED, RST_ZERO};

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic en;
		logic byte_op;
		logic [ADDR_W-1:0] addr;
	} csd_rd_req_s;

	typedef struct packed {
		logic en;
		logic byte_op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} csd_wr_req_s;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [DATA_W-1:0] data;
	} csd_rd_rsp_s;

	typedef struct packed {
		logic trap;
		logic is_write;
		logic [ADDR_W-1:0] addr;
	} csd_fault_s;

	typedef struct packed {
		logic [DATA_W-1:0] value;
	} csd_reg_state_s;

	typedef struct packed {
		csd_rd_rsp_s rsp;
		csd_fault_s fault;
	} csd_ctl_state_s;

	typedef logic [N_REGS-1:0][DATA_W-1:0] csd_bank_t;

endpackage
`default_nettype wire

// [hdl/csd_reg16.sv]
`default_nettype none
module csd_reg16 #(
	parameter logic [15:0] IMPL_MASK = 16'hFFFF,
	parameter logic [15:0] RESET_VAL = 16'h0000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [15:0] wdata,
	output logic [15:0] q
);

	csd_pkg::csd_reg_state_s state_reg;
	csd_pkg::csd_reg_state_s state_next;

	////////////////////////////////////////////////////////////////////////////////
	// two byte lanes, separate write lines
	always_comb begin
		state_next = state_reg;
		if (wr_lo) begin
			state_next.value[7:0] = wdata[7:0] & IMPL_MASK[7:0];
		end
		if (wr_hi) begin
			state_next.value[15:8] = wdata[15:8] & IMPL_MASK[15:8];
		end
		if (rst) begin
			state_next.value = RESET_VAL & IMPL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	assign q = state_reg.value;

endmodule
`default_nettype wire

// [hdl/csd_core_sfr.sv]
`default_nettype none

// What this block does
// - bytes 0000h to 07FFh of near data space form the sfr region.
// - reads of unimplemented addresses inside that region return zero.
// - decode by aligned 32-byte regions; empty regions act as unused space.
// - core registers sit in one contiguous decode group, except working reg 4 at 8000h outside the sfr region.
// - unimplemented bits read zero and ignore writes.
// - reset loads documented values; stack limit, repeat loop count and irq disable count have no defined reset.
// - two byte lanes per register; byte write hits one lane, byte read low.
// - odd word access traps; faulting write suppressed, faulting read completes.
module csd_core_sfr (
	input wire logic clk,
	input wire logic rst,
	input wire csd_pkg::csd_rd_req_s rd_req,
	input wire csd_pkg::csd_wr_req_s wr_req,
	output csd_pkg::csd_rd_rsp_s rd_rsp,
	output csd_pkg::csd_fault_s fault,
	output csd_pkg::csd_bank_t core_regs
);

	localparam logic [csd_pkg::IDX_W-1:0] NO_HIT = csd_pkg::IDX_W'(csd_pkg::N_REGS);

	csd_pkg::csd_ctl_state_s state_reg;
	csd_pkg::csd_ctl_state_s state_next;
	csd_pkg::csd_bank_t bank;
	logic [csd_pkg::IDX_W-1:0] rd_idx;
	logic [csd_pkg::IDX_W-1:0] wr_idx;
	logic rd_misaligned;
	logic wr_misaligned;
	logic wr_allowed;
	logic wr_lane_lo;
	logic wr_lane_hi;
	logic [csd_pkg::N_REGS-1:0] wr_lo_vec;
	logic [csd_pkg::N_REGS-1:0] wr_hi_vec;
	logic [15:0] rd_word;
	logic [15:0] rd_value;

	////////////////////////////////////////////////////////////////////////////////
	// address decode shared by the read and write paths

	// the core bank is one contiguous group apart from working reg 4 at 8000h: a single table walk finds the register
	function automatic logic [csd_pkg::IDX_W-1:0] find_reg(input logic [15:0] addr);
		logic [csd_pkg::IDX_W-1:0] idx;
		logic in_sfr;
		logic region_ok;
		idx = csd_pkg::IDX_W'(csd_pkg::N_REGS);
		in_sfr = (addr >= csd_pkg::SFR_FIRST) && (addr <= csd_pkg::SFR_LAST);
		region_ok = csd_pkg::REGION_IMPL[addr[csd_pkg::REGION_MSB:csd_pkg::REGION_LSB]];
		for (int i = 0; i < csd_pkg::N_REGS; i++) begin
			// word decode: the byte bit only picks the lane
			if (addr[15:1] == csd_pkg::REG_OFFSET[i][15:1] && (!in_sfr || region_ok)) begin
				idx = csd_pkg::IDX_W'(i);
			end
		end
		return idx;
	endfunction

	always_comb begin
		rd_idx = find_reg(rd_req.addr);
		wr_idx = find_reg(wr_req.addr);
	end

	////////////////////////////////////////////////////////////////////////////////
	// alignment check

	always_comb begin
		rd_misaligned = rd_req.en && !rd_req.byte_op && rd_req.addr[0];
		wr_misaligned = wr_req.en && !wr_req.byte_op && wr_req.addr[0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// write lane selection

	always_comb begin
		// a misaligned word write is dropped outright, never half applied
		wr_allowed = wr_req.en && !wr_misaligned;
		if (wr_req.byte_op) begin
			wr_lane_lo = !wr_req.addr[0];
			wr_lane_hi = wr_req.addr[0];
		end else begin
			wr_lane_lo = 1'b1;
			wr_lane_hi = 1'b1;
		end
	end

	// a miss leaves every enable low, so unused space swallows the write
	always_comb begin
		wr_lo_vec = '0;
		wr_hi_vec = '0;
		for (int i = 0; i < csd_pkg::N_REGS; i++) begin
			if (wr_allowed && wr_idx == csd_pkg::IDX_W'(i)) begin
				wr_lo_vec[i] = wr_lane_lo;
				wr_hi_vec[i] = wr_lane_hi;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register bank

	// byte writes arrive on the low byte of the data path; copy it to both lanes
	logic [15:0] wr_lane_data;
	always_comb begin
		if (wr_req.byte_op) begin
			wr_lane_data = {wr_req.data[7:0], wr_req.data[7:0]};
		end else begin
			wr_lane_data = wr_req.data;
		end
	end

	// core control bit 2 is writable; software is expected to write it back unchanged
	genvar g;
	generate
		for (g = 0; g < csd_pkg::N_REGS; g++) begin : g_bank
			csd_reg16 #(
				.IMPL_MASK(csd_pkg::REG_MASK[g]),
				.RESET_VAL(csd_pkg::REG_RESET[g])
			) u_reg (
				.clk(clk),
				.rst(rst),
				.wr_lo(wr_lo_vec[g]),
				.wr_hi(wr_hi_vec[g]),
				.wdata(wr_lane_data),
				.q(bank[g])
			);
		end
	endgenerate

	assign core_regs = bank;

	////////////////////////////////////////////////////////////////////////////////
	// read path

	always_comb begin
		rd_word = csd_pkg::READ_ZERO;
		for (int i = 0; i < csd_pkg::N_REGS; i++) begin
			if (rd_idx == csd_pkg::IDX_W'(i)) begin
				rd_word = bank[i] & csd_pkg::REG_MASK[i];
			end
		end
		if (rd_idx == NO_HIT) begin
			rd_word = csd_pkg::READ_ZERO;
		end
	end

	// a faulting word read still returns the aligned word, the trap is raised in the same cycle
	always_comb begin
		if (rd_req.byte_op) begin
			if (rd_req.addr[0]) begin
				rd_value = {8'h00, rd_word[15:8]};
			end else begin
				rd_value = {8'h00, rd_word[7:0]};
			end
		end else begin
			rd_value = rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// response and fault state

	always_comb begin
		state_next = state_reg;
		state_next.rsp.valid = rd_req.en;
		if (rd_req.en) begin
			state_next.rsp.hit = (rd_idx != NO_HIT);
			state_next.rsp.data = rd_value;
		end
		state_next.fault.trap = rd_misaligned || wr_misaligned;
		// when both sides fault in one cycle the write is reported
		if (wr_misaligned) begin
			state_next.fault.is_write = 1'b1;
			state_next.fault.addr = wr_req.addr;
		end else if (rd_misaligned) begin
			state_next.fault.is_write = 1'b0;
			state_next.fault.addr = rd_req.addr;
		end
		if (rst) begin
			state_next.rsp.valid = 1'b0;
			state_next.rsp.hit = 1'b0;
			state_next.rsp.data = csd_pkg::READ_ZERO;
			state_next.fault.trap = 1'b0;
			state_next.fault.is_write = 1'b0;
			state_next.fault.addr = '0;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	assign rd_rsp = state_reg.rsp;
	assign fault = state_reg.fault;

endmodule
`default_nettype wire

// [verification/csd_core_sfr_monitor.sv]
`default_nettype none
module csd_core_sfr_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire csd_pkg::csd_rd_req_s rd_req,
	input wire csd_pkg::csd_wr_req_s wr_req,
	input wire csd_pkg::csd_rd_rsp_s rd_rsp,
	input wire csd_pkg::csd_fault_s fault,
	input wire csd_pkg::csd_bank_t core_regs
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic rd_gap, wr_gap, rd_odd, wr_odd;
	// gap starts above the core bank regions
	assign rd_gap = rd_req.en && rd_req.addr[15:11] == 5'h00 && rd_req.addr[10:0] >= 11'h060;
	assign wr_gap = wr_req.en && wr_req.addr[15:11] == 5'h00 && wr_req.addr[10:0] >= 11'h060;
	assign rd_odd = rd_req.en && !rd_req.byte_op && rd_req.addr[0];
	assign wr_odd = wr_req.en && !wr_req.byte_op && wr_req.addr[0];
	////////////////////////////////////////
	AST_HIT: assert property (rd_req.en && rd_req.addr == 16'h001E |=> rd_rsp.hit)
		else $error("core bank read missed");
	AST_GAP_RD: assert property (rd_gap |=> rd_rsp.data == 16'h0000 && !rd_rsp.hit)
		else $error("unused read not zero");
	AST_GAP_WR: assert property (wr_gap |=> core_regs == $past(core_regs) && !fault.trap)
		else $error("unused write had effect");
	AST_MASK: assert property (core_regs[18][15:8] == 8'h00 && core_regs[19][15:10] == 6'h00
		&& core_regs[20][15:9] == 7'h00 && core_regs[25][15:8] == 8'h00) else $error("unused bit set");
	AST_RESET: assert property ($fell(rst) |-> core_regs[15] == 16'h0800 && core_regs[0] == 16'h0000
		&& core_regs[19] == 16'h0001 && core_regs[20] == 16'h0001 && core_regs[23] == 16'h0004)
		else $error("reset value wrong");
	AST_BYTE_WR: assert property (wr_req.en && wr_req.byte_op && wr_req.addr == 16'h0003 |=>
		core_regs[1] == {$past(wr_req.data[7:0]), $past(core_regs[1][7:0])}) else $error("byte lane");
	AST_BYTE_RD: assert property (rd_req.en && rd_req.byte_op |=> rd_rsp.data[15:8] == 8'h00)
		else $error("byte read high not zero");
	AST_ODD_RD: assert property (rd_odd |=> fault.trap && !fault.is_write
		&& fault.addr == $past(rd_req.addr)) else $error("odd read no trap");
	AST_ODD_WR: assert property (wr_odd |=> fault.trap && fault.is_write
		&& core_regs == $past(core_regs)) else $error("odd write not suppressed");
	AST_TRAP_CAUSE: assert property (fault.trap |-> $past(rd_odd || wr_odd))
		else $error("trap without cause");
endmodule
bind csd_core_sfr csd_core_sfr_monitor csd_core_sfr_monitor_i (.clk(clk), .rst(rst),
	.rd_req(rd_req), .wr_req(wr_req), .rd_rsp(rd_rsp), .fault(fault), .core_regs(core_regs));
`default_nettype wire

// [verification/csd_cpu_agu.sv]
`default_nettype none
module csd_cpu_agu (
	input wire logic clk,
	input wire csd_pkg::csd_rd_rsp_s rd_rsp,
	output var csd_pkg::csd_rd_req_s rd_req,
	output var csd_pkg::csd_wr_req_s wr_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rd_req = '0;
		wr_req = '0;
	end
	// released lines are inverted so a stale value never passes for a live one
	task automatic rd(input logic [15:0] a, input logic b, output logic [15:0] d);
		@(posedge clk) #1;
		rd_req = '{en: 1'b1, byte_op: b, addr: a};
		@(posedge clk) #1;
		d = rd_rsp.data;
		rd_req = '{en: 1'b0, byte_op: ~b, addr: ~a};
	endtask
	task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] v);
		@(posedge clk) #1;
		wr_req = '{en: 1'b1, byte_op: b, addr: a, data: v};
		@(posedge clk) #1;
		wr_req = '{en: 1'b0, byte_op: ~b, addr: ~a, data: ~v};
	endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	csd_pkg::csd_rd_req_s rd_req;
	csd_pkg::csd_wr_req_s wr_req;
	csd_pkg::csd_rd_rsp_s rd_rsp;
	csd_pkg::csd_fault_s fault;
	csd_pkg::csd_bank_t core_regs;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	logic [15:0] d;
	logic [15:0] gap [4] = '{16'h0008, 16'h0022, 16'h0060, 16'h07FE};
	always #50 clk = ~clk;
	csd_core_sfr csd_core_sfr_i (.clk(clk), .rst(rst), .rd_req(rd_req), .wr_req(wr_req),
		.rd_rsp(rd_rsp), .fault(fault), .core_regs(core_regs));
	csd_cpu_agu csd_cpu_agu_i (.clk(clk), .rd_rsp(rd_rsp), .rd_req(rd_req), .wr_req(wr_req));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic rchk(input string n, input logic [15:0] a, input logic b, input logic [15:0] e,
		input logic h);
		csd_cpu_agu_i.rd(a, b, d);
		// the answer stands for one cycle only, so look right after the taking edge
		chk(n, {15'h0000, rd_rsp.valid}, 16'h0001);
		chk(n, d, e);
		chk(n, {15'h0000, rd_rsp.hit}, {15'h0000, h});
	endtask
	function automatic logic [15:0] rst_val(input int i);
		case (i)
			15: return 16'h0800;
			19, 20: return 16'h0001;
			23: return 16'h0004;
			default: return 16'h0000;
		endcase
	endfunction
	// undefined reset registers are skipped
	task automatic rst_chk();
		@(posedge clk) #1;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < csd_pkg::N_REGS; i++) begin
			if (i != 16 && i != 21 && i != 24) begin
				rchk("reset", csd_pkg::REG_OFFSET[i], 1'b0, rst_val(i), 1'b1);
			end
		end
	endtask
	////////////////////////////////////////
	initial begin
		rst_chk();
		for (int i = 0; i < csd_pkg::N_REGS; i++) begin
			// control bit 2 is already set, so all ones keeps it
			csd_cpu_agu_i.wr(csd_pkg::REG_OFFSET[i], 1'b0, 16'hFFFF);
			rchk("mask", csd_pkg::REG_OFFSET[i], 1'b0, csd_pkg::REG_MASK[i], 1'b1);
		end
		csd_cpu_agu_i.wr(16'h0002, 1'b0, 16'h1234);
		csd_cpu_agu_i.wr(16'h0003, 1'b1, 16'h55AB);
		csd_cpu_agu_i.wr(16'h0004, 1'b1, 16'h77CD);
		rchk("word", 16'h0002, 1'b0, 16'hAB34, 1'b1);
		rchk("lane lo", 16'h0004, 1'b0, 16'hFFCD, 1'b1);
		rchk("byte hi", 16'h0003, 1'b1, 16'h00AB, 1'b1);
		rchk("byte lo", 16'h0002, 1'b1, 16'h0034, 1'b1);
		csd_cpu_agu_i.wr(16'h0003, 1'b0, 16'h5555);
		chk("wr trap", {14'h0000, fault.trap, fault.is_write}, 16'h0003);
		rchk("odd rd", 16'h0003, 1'b0, 16'hAB34, 1'b1);
		chk("rd trap", {14'h0000, fault.trap, fault.is_write}, 16'h0002);
		chk("trap addr", fault.addr, 16'h0003);
		foreach (gap[k]) begin
			csd_cpu_agu_i.wr(gap[k], 1'b0, 16'hA5A5);
			rchk("gap", gap[k], 1'b0, 16'h0000, 1'b0);
		end
		// neighbours of the gap writes must still hold what the mask pass left
		rchk("gap keep", 16'h0006, 1'b0, 16'hFFFF, 1'b1);
		rchk("gap keep", 16'h0020, 1'b0, 16'hFFFF, 1'b1);
		rchk("alias", 16'h8000, 1'b0, 16'hFFFF, 1'b1);
		rst_chk();
		print_verdict();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
endmodule
`default_nettype wire
